// file: logic/twsng_slave.sv
// Two-wire slave engine: start/stop, address match, acknowledge, write
// and read bytes, nonvolatile busy period and write protection.
// Assumes scl_clk is the bus clock pin itself, driven only by the master.
//
// Function
// R1: Start is SDA fall with SCL high
// R2: Stop is SDA rise with SCL high
// R3: Master ends every operation with stop
// R4: SDA change during SCL high means start/stop
// R5: Master starts only on an idle bus
// R6: Master drives SCL; slave never clocks
// R7: Address byte equals type code plus straps
// R8: Acknowledge matching address, silent on mismatch
// R9: Receiver pulls SDA low on ninth clock
// R10: Acknowledge every write byte unless protected
// R11: Read mode sends eight bits, checks ack
// R12: No master ack: release, await stop
// R13: Write is address, instruction, data, stop
// R14: Nonvolatile write programs after stop, 5 ms
// R15: While programming ignore bus, SDA released
// R16: Polling acknowledged only after programming ends
// R17: Write protect withholds data-byte acknowledge; the code withholds it only for OP_WR_STORED data bytes
// R18: Protect falling after start aborts write
// R19: Master waits after power-up before access
// R20: Master keeps bus idle between stop, start
// R21: Glitches up to 50 ns suppressed
// R22: Instruction: opcode, register select, pot select
// R23: Register select picks stored register 0-3
// R24: After mismatch ignore bytes until start
// R25: Start mid-sequence restarts at address byte
`timescale 1ns/10ps
module twsng_slave #(
    parameter int PROG_CYCLES = twsng_pkg::NV_PROGRAM_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic addr_strap_bit3,
    input wire logic wp_n,
    input wire logic [7:0] rd_data,
    output logic [3:0] instr_opcode,
    output logic reg_select_hi,
    output logic reg_select_lo,
    output logic [1:0] pot_select,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    output logic nv_program_start,
    output logic busy
);
    // Is the opcode one that makes the slave transmit
    function automatic logic is_read(input logic [3:0] op);
        is_read = (op == twsng_pkg::OP_RD_WIPER) || (op == twsng_pkg::OP_RD_STORED);
    endfunction

    // Link domain: bit sampled on each rising SCL, with an event toggle
    logic link_bit;
    logic link_tog;
    logic next_link_bit;
    logic next_link_tog;

    // Next link values
    always_comb begin
        next_link_bit = sda_in;
        next_link_tog = ~link_tog;
    end

    // Link registers; reset is a constant only
    always_ff @(posedge scl_clk or posedge srst) begin
        if (srst) begin
            link_bit <= 1'b0;
            link_tog <= 1'b0;
        end else begin
            link_bit <= next_link_bit;
            link_tog <= next_link_tog;
        end
    end

    // Filtered views of the bus in the system domain
    logic scl_f;
    logic sda_f;

    twsng_glitch_filter u_scl_filt (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .raw(scl_clk),
        .filt(scl_f)
    );

    twsng_glitch_filter u_sda_filt (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .raw(sda_in),
        .filt(sda_f)
    );

    // Crossing and pin synchronisers
    logic tog_s1; // First stage of toggle crossing
    logic tog_s2;
    logic tog_s3; // Previous toggle, for change detection
    logic bit_s1; // First stage of bit crossing
    logic bit_s2;
    logic [4:0] pin_s1; // First stage: {wp_n, straps}
    logic [4:0] pin_s2;
    logic scl_d; // Filtered SCL one cycle ago
    logic sda_d; // Filtered SDA one cycle ago
    logic wp_d; // Synchronised protect one cycle ago
    logic bit_pend; // A rising SCL not yet consumed

    logic start_ev;
    logic stop_ev;
    logic scl_fall;
    logic bit_ev;
    logic wp_s;
    logic [3:0] straps;
    logic next_bit_pend;

    assign start_ev = scl_f && scl_d && sda_d && !sda_f; // R1 R4
    assign stop_ev = scl_f && scl_d && !sda_d && sda_f; // R2 R4
    assign scl_fall = scl_d && !scl_f;
    assign bit_ev = bit_pend && scl_f; // R21
    assign wp_s = pin_s2[4];
    assign straps = pin_s2[3:0];

    // Rising edge is kept pending until filtered SCL confirms it
    always_comb begin
        if (tog_s2 != tog_s3) begin
            next_bit_pend = 1'b1;
        end else if (bit_ev || scl_fall) begin
            next_bit_pend = 1'b0;
        end else begin
            next_bit_pend = bit_pend;
        end
    end

    // Synchroniser and edge registers
    always_ff @(posedge clock) begin
        if (srst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            bit_s1 <= 1'b0;
            bit_s2 <= 1'b0;
            pin_s1 <= 5'h10;
            pin_s2 <= 5'h10;
            scl_d <= twsng_pkg::BUS_IDLE_LEVEL;
            sda_d <= twsng_pkg::BUS_IDLE_LEVEL;
            wp_d <= 1'b1;
            bit_pend <= 1'b0;
        end else if (ce) begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            bit_s1 <= link_bit;
            bit_s2 <= bit_s1;
            pin_s1 <= {wp_n, addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            pin_s2 <= pin_s1;
            scl_d <= scl_f;
            sda_d <= sda_f;
            wp_d <= wp_s;
            bit_pend <= next_bit_pend;
        end
    end

    // Protocol engine state
    twsng_pkg::twsng_state_t state;
    twsng_pkg::twsng_state_t next_state;
    logic [3:0] cnt; // Bit counter within a byte
    logic [7:0] shreg; // Receive or transmit shifter
    logic [1:0] byte_idx; // Byte position, saturates at extra
    logic [7:0] instr; // Latched instruction byte
    logic nv_armed; // Stored-register write awaiting stop
    logic wp_abort; // Protect fell during this transaction
    logic [15:0] prog_cnt; // Programming cycles left
    logic [3:0] next_cnt;
    logic [7:0] next_shreg;
    logic [1:0] next_byte_idx;
    logic [7:0] next_instr;
    logic next_nv_armed;
    logic next_wp_abort;
    logic [15:0] next_prog_cnt;
    logic next_sda_oe;
    logic [7:0] next_wr_data;
    logic next_wr_strobe;
    logic next_nv_start;
    logic next_busy;
    logic [7:0] rx_byte;
    logic ack;

    assign rx_byte = {shreg[6:0], bit_s2};
    assign instr_opcode = instr[twsng_pkg::OPC_MSB:twsng_pkg::OPC_LSB]; // R22
    assign reg_select_hi = instr[twsng_pkg::SEL_HI_POS]; // R23
    assign reg_select_lo = instr[twsng_pkg::SEL_LO_POS]; // R23
    assign pot_select = instr[twsng_pkg::POT_MSB:twsng_pkg::POT_LSB]; // R22

    // Next values of the engine
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_byte_idx = byte_idx;
        next_instr = instr;
        next_nv_armed = nv_armed;
        next_wp_abort = wp_abort;
        next_prog_cnt = prog_cnt;
        next_sda_oe = sda_oe;
        next_wr_data = wr_data;
        next_wr_strobe = 1'b0;
        next_nv_start = 1'b0;
        next_busy = busy;
        ack = 1'b0;
        // Programming countdown, unaffected by protect once running
        if (busy) begin
            if (prog_cnt == 16'h0000) begin
                next_busy = 1'b0; // R16
            end else begin
                next_prog_cnt = prog_cnt - 16'h0001;
            end
        end
        // Protect falling inside a transaction cancels the pending write
        if (wp_d && !wp_s && state != twsng_pkg::ST_IDLE) begin
            next_wp_abort = 1'b1; // R18
        end else if (start_ev) begin
            next_wp_abort = 1'b0;
        end
        if (stop_ev) begin
            // Stop ends everything; a clean stored write starts programming
            next_state = twsng_pkg::ST_IDLE; // R2
            next_sda_oe = 1'b0;
            next_nv_armed = 1'b0;
            if (nv_armed && !wp_abort && wp_s && !busy) begin
                next_nv_start = 1'b1; // R14
                next_busy = 1'b1; // R14
                next_prog_cnt = 16'(PROG_CYCLES - 1);
            end
        end else if (start_ev) begin
            // Start, also mid-sequence, expects an address byte
            next_state = twsng_pkg::ST_RX; // R1 R25
            next_cnt = 4'h0;
            next_byte_idx = twsng_pkg::BYTE_ADDR; // R25
            next_sda_oe = 1'b0;
            next_nv_armed = 1'b0;
        end else begin
            case (state)
                twsng_pkg::ST_RX: begin
                    if (bit_ev) begin
                        next_shreg = rx_byte;
                        next_cnt = cnt + 4'h1;
                        if (cnt == twsng_pkg::LAST_BIT) begin
                            // Full byte in: decide whether to acknowledge
                            if (byte_idx == twsng_pkg::BYTE_ADDR) begin
                                ack = (rx_byte == {twsng_pkg::DEV_TYPE, straps}) && !busy; // R7 R8 R15
                            end else if (byte_idx == twsng_pkg::BYTE_INSTR) begin
                                ack = 1'b1; // R10 R17
                                next_instr = rx_byte;
                            end else if (byte_idx == twsng_pkg::BYTE_DATA) begin
                                ack = !(instr_opcode == twsng_pkg::OP_WR_STORED && !wp_s); // R17
                                next_wr_strobe = ack && !is_read(instr_opcode); // R10
                                next_wr_data = rx_byte;
                                next_nv_armed = ack && (instr_opcode == twsng_pkg::OP_WR_STORED);
                            end else begin
                                ack = 1'b1; // R10
                            end
                            if (byte_idx != twsng_pkg::BYTE_EXTRA) begin
                                next_byte_idx = byte_idx + 2'h1;
                            end
                            next_state = ack ? twsng_pkg::ST_ACKP : twsng_pkg::ST_WAIT; // R8 R24
                        end
                    end
                end
                twsng_pkg::ST_ACKP: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b1; // R9
                        next_state = twsng_pkg::ST_ACK;
                    end
                end
                twsng_pkg::ST_ACK: begin
                    // End of ninth clock: release, or go on to transmit
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (is_read(instr_opcode) && byte_idx == twsng_pkg::BYTE_DATA) begin
                            next_shreg = rd_data; // R11
                            next_sda_oe = !rd_data[7];
                            next_state = twsng_pkg::ST_TX;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = twsng_pkg::ST_RX;
                        end
                    end
                end
                twsng_pkg::ST_TX: begin
                    // Shift out on each falling SCL, release after bit 0
                    if (scl_fall) begin
                        if (cnt == twsng_pkg::LAST_BIT) begin
                            next_sda_oe = 1'b0; // R11
                            next_state = twsng_pkg::ST_MACK;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_sda_oe = !shreg[6];
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                twsng_pkg::ST_MACK: begin
                    if (bit_ev) begin
                        next_state = bit_s2 ? twsng_pkg::ST_WAIT : twsng_pkg::ST_TXGO; // R11 R12
                    end
                end
                twsng_pkg::ST_TXGO: begin
                    if (scl_fall) begin
                        next_shreg = rd_data; // R11
                        next_sda_oe = !rd_data[7];
                        next_cnt = 4'h0;
                        next_state = twsng_pkg::ST_TX;
                    end
                end
                default: begin
                    // Idle and wait: bus ignored until start or stop
                    next_sda_oe = 1'b0; // R12 R24
                end
            endcase
        end
    end

    // Engine registers
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= twsng_pkg::ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            byte_idx <= twsng_pkg::BYTE_ADDR;
            instr <= twsng_pkg::INSTR_RESET;
            nv_armed <= 1'b0;
            wp_abort <= 1'b0;
            prog_cnt <= 16'h0000;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            wr_data <= 8'h00;
            wr_strobe <= 1'b0;
            nv_program_start <= 1'b0;
            busy <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            byte_idx <= next_byte_idx;
            instr <= next_instr;
            nv_armed <= next_nv_armed;
            wp_abort <= next_wp_abort;
            prog_cnt <= next_prog_cnt;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
            wr_data <= next_wr_data;
            wr_strobe <= next_wr_strobe;
            nv_program_start <= next_nv_start;
            busy <= next_busy;
        end
    end

    // Checks on the engine
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_addr_done;
        ce && bit_ev && state == twsng_pkg::ST_RX && cnt == twsng_pkg::LAST_BIT
            && byte_idx == twsng_pkg::BYTE_ADDR;
    endsequence

    a_start_rx: assert property (ce && start_ev && !stop_ev |=> state == twsng_pkg::ST_RX // R1
        && byte_idx == twsng_pkg::BYTE_ADDR && cnt == 4'h0) else $error("start not taken"); // R25
    a_stop_idle: assert property (ce && stop_ev |=> state == twsng_pkg::ST_IDLE && !sda_oe) // R2
        else $error("stop not taken");
    a_addr_match: assert property (s_addr_done ##0 (rx_byte != {twsng_pkg::DEV_TYPE, straps}) // R8
        |=> state == twsng_pkg::ST_WAIT) else $error("mismatch acknowledged");
    a_busy_ignore: assert property (s_addr_done ##0 busy |=> state == twsng_pkg::ST_WAIT) // R15
        else $error("address acknowledged while busy");
    a_busy_quiet: assert property (busy |-> !sda_oe) else $error("sda driven while busy"); // R15
    a_ack_ninth: assert property (ce && state == twsng_pkg::ST_ACKP && scl_fall && !start_ev // R9
        && !stop_ev |=> sda_oe ##0 state == twsng_pkg::ST_ACK) else $error("ack not driven");
    a_wp_nack: assert property (ce && bit_ev && state == twsng_pkg::ST_RX // R17
        && cnt == twsng_pkg::LAST_BIT && byte_idx == twsng_pkg::BYTE_DATA && !wp_s
        && instr_opcode == twsng_pkg::OP_WR_STORED && !start_ev && !stop_ev
        |=> state == twsng_pkg::ST_WAIT && !nv_armed) else $error("protected write acked");
    a_master_nack: assert property (ce && state == twsng_pkg::ST_MACK && bit_ev && bit_s2 // R12
        && !start_ev && !stop_ev |=> state == twsng_pkg::ST_WAIT [*2]) else $error("nack ignored");
    a_abort_wp: assert property (ce && wp_abort && stop_ev |=> !nv_program_start) // R18
        else $error("aborted write programmed");
    a_prog_start: assert property (nv_program_start |-> busy && prog_cnt == 16'(PROG_CYCLES - 1) // R14
        && $past(nv_armed)) else $error("programming start wrong");
endmodule // twsng_slave

// file: inc/twsng_pkg.sv
// Constants shared by the two-wire slave with nonvolatile write guard.
// Assumes a 10 MHz system clock; all cycle counts derive from that rate.
package twsng_pkg;
    // System clock period in nanoseconds
    localparam int SYS_CLK_NS = 100;

    // Device-type code in the upper address nibble; value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'ha;

    // Instruction opcodes, upper nibble of the instruction byte
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'ha;
    localparam logic [3:0] OP_RD_STORED = 4'hb;
    localparam logic [3:0] OP_WR_STORED = 4'hc;

    // Instruction byte field positions
    localparam int OPC_MSB = 7;
    localparam int OPC_LSB = 4;
    localparam int SEL_HI_POS = 3;
    localparam int SEL_LO_POS = 2;
    localparam int POT_MSB = 1;
    localparam int POT_LSB = 0;

    // Byte positions inside one transaction
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_INSTR = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;
    localparam logic [1:0] BYTE_EXTRA = 2'h3;

    // Bits per byte, last bit index
    localparam logic [3:0] LAST_BIT = 4'h7;

    // Nonvolatile programming time, longest figure, rounded down to cycles
    localparam int NV_PROGRAM_TIME_MS = 5;
    localparam int NV_PROGRAM_CYCLES = (NV_PROGRAM_TIME_MS * 1000000) / SYS_CLK_NS;

    // Glitch suppression time, rounded up; one extra sample rejects it
    localparam int GLITCH_FILTER_TIME_NS = 50;
    localparam int GLITCH_CYCLES = (GLITCH_FILTER_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [1:0] GLITCH_LAST = 2'(GLITCH_CYCLES);

    // Reset values
    localparam logic BUS_IDLE_LEVEL = 1'b1;
    localparam logic [7:0] INSTR_RESET = 8'h00;

    // Protocol engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACKP = 3'b010,
        ST_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_MACK = 3'b101,
        ST_TXGO = 3'b110,
        ST_WAIT = 3'b111
    } twsng_state_t;
endpackage

// file: logic/twsng_glitch_filter.sv
// Two-flop synchroniser followed by a persistence filter for one bus line.
// Assumes the raw line is asynchronous to clock and idles high.
`timescale 1ns/10ps
module twsng_glitch_filter (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic raw,
    output logic filt
);
    logic s1; // First synchroniser stage
    logic s2; // Second synchroniser stage
    logic [1:0] run; // Consecutive samples differing from filt
    logic [1:0] next_run;
    logic next_filt;

    // Output follows only after a change persists past the glitch time
    always_comb begin
        next_run = run;
        next_filt = filt;
        if (s2 == filt) begin
            next_run = 2'h0;
        end else if (run == twsng_pkg::GLITCH_LAST) begin
            next_filt = s2; // R21
            next_run = 2'h0;
        end else begin
            next_run = run + 2'h1;
        end
    end

    // Register stage
    always_ff @(posedge clock) begin
        if (srst) begin
            s1 <= twsng_pkg::BUS_IDLE_LEVEL;
            s2 <= twsng_pkg::BUS_IDLE_LEVEL;
            filt <= twsng_pkg::BUS_IDLE_LEVEL;
            run <= 2'h0;
        end else if (ce) begin
            s1 <= raw;
            s2 <= s1;
            filt <= next_filt;
            run <= next_run;
        end
    end
endmodule // twsng_glitch_filter

// file: testbench/twsng_master_model.sv
// Behavioural two-wire bus master that drives SCL and pulls SDA low.
// Assumes a pull-up on SDA: the wire reads high unless someone pulls it.
`timescale 1ns/10ps
module twsng_master_model #(
    parameter int T = 160
) (
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    // Bus idles released, clock standing high outside frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // One bit: data set while SCL is low, held through the high phase
    task automatic bit_cyc(input logic b, output logic r);
        #(T); // Hold time after SCL fall, so SDA never moves with it
        sda_pull = ~b;
        #(T * 7);
        scl = 1'b1;
        #(T * 2);
        r = sda_wire;
        #(T * 3);
        scl = 1'b0;
    endtask
    // Eight bits MSB first, then the acknowledge clock
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], q[i]);
        end
        bit_cyc(ack_in, ack);
    endtask
    // Start, also usable as a repeated start
    task automatic start_cond;
        #(T);
        sda_pull = 1'b0;
        #(T * 4);
        scl = 1'b1;
        #(T * 4);
        sda_pull = 1'b1;
        #(T * 4);
        scl = 1'b0;
    endtask
    // Stop, then the bus is left idle before any new start
    task automatic stop_cond;
        #(T);
        sda_pull = 1'b1;
        #(T * 4);
        scl = 1'b1;
        #(T * 4);
        sda_pull = 1'b0;
        #(T * 8);
    endtask
    // Short SDA dip with SCL high, too brief to count as a start
    task automatic glitch;
        sda_pull = 1'b1;
        #50;
        sda_pull = 1'b0;
        #(T * 4);
        scl = 1'b0;
    endtask
endmodule // twsng_master_model

// file: testbench/test_two_wire_slave_nv_write_guard.sv
// Self-checking bench for the two-wire slave with nonvolatile write guard.
// Assumes the master model file and an SDA wire with a pull-up.
`timescale 1ns/10ps
module test_two_wire_slave_nv_write_guard;
    localparam int PROG = 400; // Shortened programming time
    logic clock = 1'b0; // System clock
    logic srst = 1'b1; // Reset, held at start
    logic wp_n = 1'b1; // Write protect, active low
    logic [3:0] straps = 4'h0; // Address straps
    logic [7:0] rd_data = 8'h00; // Byte offered in read mode
    logic scl, m_pull, sda_out, sda_oe, reg_select_hi, reg_select_lo;
    logic wr_strobe, nv_program_start, busy, ack, strobe_d = 1'b0;
    logic [3:0] instr_opcode;
    logic [1:0] pot_select;
    logic [7:0] wr_data, q, own, ins, d, r0;
    logic [7:0] exp_q[$]; // Bytes the model expects to be stored
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 32'hc0c3;
    int busy_run = 0;
    int busy_len = 0;
    int n_prog = 0;
    int exp_prog = 0;
    wire logic sda = ~(sda_oe | m_pull); // Open-drain wire, pulled up
    twsng_slave #(.PROG_CYCLES(PROG)) twsng_slave_i (
        .clock(clock), .srst(srst), .ce(1'b1), .scl_clk(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(straps[0]),
        .addr_strap_bit1(straps[1]), .addr_strap_bit2(straps[2]),
        .addr_strap_bit3(straps[3]), .wp_n(wp_n), .rd_data(rd_data),
        .instr_opcode(instr_opcode), .reg_select_hi(reg_select_hi),
        .reg_select_lo(reg_select_lo), .pot_select(pot_select), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .nv_program_start(nv_program_start), .busy(busy));
    twsng_master_model mm_i (.sda_wire(sda), .scl(scl), .sda_pull(m_pull));
    always #50 clock = ~clock;
    // Compare and count one result
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic test_done;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Busy length, programming starts and stored bytes
    always @(posedge clock) begin
        strobe_d <= wr_strobe;
        if (busy === 1'b1) begin
            busy_run <= busy_run + 1;
        end else if (busy_run != 0) begin
            busy_len <= busy_run;
            busy_run <= 0;
        end
        if (nv_program_start === 1'b1) begin
            n_prog <= n_prog + 1;
        end
        if (strobe_d === 1'b1) begin
            check("wr_data", (exp_q.size() > 0) ? exp_q.pop_front() : 'x, wr_data);
        end
    end
    // Model of which bytes earn an acknowledge
    function automatic logic [2:0] exp_acks(input logic [7:0] a, input logic [7:0] i);
        if (a !== {twsng_pkg::DEV_TYPE, straps}) return 3'b111;
        if (i[7:4] === twsng_pkg::OP_WR_STORED && wp_n !== 1'b1) return 3'b001;
        return 3'b000;
    endfunction
    // Full three-byte write against the expected acknowledge pattern
    task automatic write3(input logic [7:0] a, input logic [7:0] i, input logic [7:0] v,
                          input logic [2:0] exp);
        logic [2:0] acks;
        if (exp === 3'b000) begin
            exp_q.push_back(v);
            exp_prog += (i[7:4] === twsng_pkg::OP_WR_STORED);
        end
        mm_i.start_cond;
        mm_i.xfer(a, 1'b1, q, acks[2]);
        mm_i.xfer(i, 1'b1, q, acks[1]);
        mm_i.xfer(v, 1'b1, q, acks[0]);
        mm_i.stop_cond;
        check("acks", exp, acks);
    endtask
    // Address-only poll
    task automatic poll(input logic exp);
        mm_i.start_cond;
        mm_i.xfer(own, 1'b1, q, ack);
        mm_i.stop_cond;
        check("poll ack", exp, ack);
    endtask
    // Bounded wait for the programming period to end
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge clock);
            #1;
            k++;
        end
        if (k >= 2000) begin
            error_cnt++;
            test_done;
        end
    endtask
    // Main sequence
    initial begin
        straps = 4'($random(seed));
        own = {twsng_pkg::DEV_TYPE, straps};
        repeat (2) @(posedge clock);
        #5 srst = 1'b0;
        repeat (10) @(posedge clock);
        #5;
        ins = {twsng_pkg::OP_WR_STORED, 4'($random(seed))};
        d = 8'($random(seed));
        write3(own, ins, d, 3'b000);
        check("opcode", ins[7:4], instr_opcode);
        check("select", ins[3:0], {reg_select_hi, reg_select_lo, pot_select});
        poll(1'b1);
        #5 wp_n = 1'b0;
        wait_idle;
        @(posedge clock);
        #1;
        check("busy cycles", PROG, busy_len);
        #5 wp_n = 1'b1;
        poll(1'b0);
        // Protected from the start, then protect dropping mid-write
        wp_n = 1'b0;
        write3(own, ins, d, exp_acks(own, ins));
        wp_n = 1'b1;
        // Short protect pulse in the instruction byte: data acked, nothing programs
        fork
            write3(own, ins, d, 3'b000);
            begin
                #25000;
                @(posedge clock);
                #5 wp_n = 1'b0;
                repeat (5) @(posedge clock);
                #5 wp_n = 1'b1;
            end
        join
        exp_prog--;
        check("programs", exp_prog, n_prog);
        write3(own, {twsng_pkg::OP_WR_WIPER, 4'h1}, 8'($random(seed)), 3'b000);
        for (int i = 0; i < 8; i++) begin
            write3(own ^ (8'h01 << i), ins, d, exp_acks(own ^ (8'h01 << i), ins));
        end
        // Read two bytes: ack the first, refuse the second
        rd_data = 8'($random(seed));
        r0 = rd_data;
        mm_i.start_cond;
        mm_i.xfer(own, 1'b1, q, ack);
        mm_i.xfer({twsng_pkg::OP_RD_STORED, 4'h6}, 1'b1, q, ack);
        fork
            mm_i.xfer(8'hff, 1'b0, q, ack);
            begin
                #5000;
                @(posedge clock);
                #5 rd_data = ~r0;
            end
        join
        check("read byte", r0, q);
        mm_i.xfer(8'hff, 1'b1, q, ack);
        check("second byte", 8'(~r0), q);
        mm_i.bit_cyc(1'b1, ack);
        check("released", 1'b1, ack);
        mm_i.stop_cond;
        // A glitch is no start; a repeated start restarts addressing
        mm_i.glitch;
        mm_i.xfer(own, 1'b1, q, ack);
        check("no start", 1'b1, ack);
        mm_i.start_cond;
        mm_i.xfer(own ^ 8'h01, 1'b1, q, ack);
        mm_i.start_cond;
        mm_i.xfer(own, 1'b1, q, ack);
        check("restart ack", 1'b0, ack);
        mm_i.stop_cond;
        check("programs", exp_prog, n_prog);
        check("sda_out", 1'b0, sda_out);
        test_done;
    end
endmodule // test_two_wire_slave_nv_write_guard
